// ==== rtl/tewsh_edge_shaper.sv ====
// Behaviour
// - Type V falling target is residual level
// - Types 1..3 give 1..3 linear segments
// - Types 4..6 use table, adaptation per code
// - Low nibble selects rising edge type
// - Falling style: time constant or table number
// - Rising style: time constant or table number
// - Stretch bit doubles each state's carrier cycles
// - Length field counts states for both edges
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module tewsh_edge_shaper (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// Transmitter control
	input wire logic modeTypeV,
	input wire logic frameActive,
	input wire logic txModulate,
	input wire logic carrierTick,
	input wire logic [7:0] amplifierSupply,
	// Amplitude control
	output logic [7:0] amplitude,
	output logic edgeActive
);
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic isFwType(input logic [3:0] code);
		return (code >= tewsh_pkg::TYPE_FW_ONE) && (code <= tewsh_pkg::TYPE_FW_THREE);
	endfunction

	function automatic logic isLutType(input logic [3:0] code);
		return (code >= tewsh_pkg::TYPE_LUT_PLAIN) && (code <= tewsh_pkg::TYPE_LUT_NOCORR);
	endfunction

	// Two linear segments meeting at the knee
	function automatic logic [7:0] kneeMap(input logic [7:0] p, input logic [7:0] y1);
		logic [15:0] t;
		if (p < tewsh_pkg::KNEE_INPUT)
		begin
			t = 16'(p) * 16'(y1);
			return t[14:7];
		end
		t = 16'(p - tewsh_pkg::KNEE_INPUT) * 16'(8'hff - y1);
		return y1 + t[14:7];
	endfunction

	function automatic logic [7:0] stepProgress(input logic [4:0] idx, input logic [4:0] len);
		logic [12:0] num;
		logic [12:0] quo;
		num = (13'(idx) + 13'h001) * 13'h0ff;
		quo = (len == 5'h00) ? 13'h0ff : num / 13'(len);
		return quo[7:0];
	endfunction

	function automatic logic [7:0] lerpAmp(input logic [7:0] from, input logic [7:0] to,
		input logic [7:0] p);
		logic signed [9:0] diff;
		logic signed [18:0] prod;
		logic signed [18:0] sum;
		diff = $signed({2'b00, to}) - $signed({2'b00, from});
		prod = 19'(diff) * $signed({11'h000, p});
		sum = $signed({11'h000, from}) + prod / 19'sh000ff;
		return sum[7:0];
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] residual424k_reg;
	logic [7:0] type424k_reg;
	logic [7:0] style424k_reg;
	logic [7:0] length424k_reg;
	logic [7:0] residualV_reg;
	logic [7:0] typeV_reg;
	logic [7:0] styleV_reg;
	logic [7:0] lengthV_reg;

	// Reserved bits are dropped on write so they read back as zero
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			residual424k_reg <= tewsh_pkg::RST_RESIDUAL;
			type424k_reg <= tewsh_pkg::RST_TYPE;
			style424k_reg <= tewsh_pkg::RST_STYLE;
			length424k_reg <= tewsh_pkg::RST_LENGTH;
			residualV_reg <= tewsh_pkg::RST_RESIDUAL;
			typeV_reg <= tewsh_pkg::RST_TYPE;
			styleV_reg <= tewsh_pkg::RST_STYLE;
			lengthV_reg <= tewsh_pkg::RST_LENGTH;
		end
		else if (regWrEn)
		begin
			case (regAddr)
				tewsh_pkg::OFS_RESIDUAL_424K: residual424k_reg <= regWrData;
				tewsh_pkg::OFS_TYPE_424K: type424k_reg <= regWrData;
				tewsh_pkg::OFS_STYLE_424K: style424k_reg <= regWrData & tewsh_pkg::MASK_STYLE;
				tewsh_pkg::OFS_LENGTH_424K: length424k_reg <= regWrData & tewsh_pkg::MASK_LENGTH;
				tewsh_pkg::OFS_RESIDUAL_TYPEV: residualV_reg <= regWrData;
				tewsh_pkg::OFS_TYPE_TYPEV: typeV_reg <= regWrData;
				tewsh_pkg::OFS_STYLE_TYPEV: styleV_reg <= regWrData & tewsh_pkg::MASK_STYLE;
				tewsh_pkg::OFS_LENGTH_TYPEV: lengthV_reg <= regWrData & tewsh_pkg::MASK_LENGTH;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Parameter set of the running frame
	// ************************************************************
	logic frameActiveDly_reg;
	logic activeTypeV_reg;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			frameActiveDly_reg <= 1'b0;
			activeTypeV_reg <= 1'b0;
		end
		else
		begin
			frameActiveDly_reg <= frameActive;
			if (frameActive && !frameActiveDly_reg)
				activeTypeV_reg <= modeTypeV;
		end
	end

	logic [7:0] cfgType;
	logic [7:0] cfgStyle;
	logic [7:0] cfgLength;
	logic [7:0] cfgResidual;

	assign cfgType = activeTypeV_reg ? typeV_reg : type424k_reg;
	assign cfgStyle = activeTypeV_reg ? styleV_reg : style424k_reg;
	assign cfgLength = activeTypeV_reg ? lengthV_reg : length424k_reg;
	assign cfgResidual = activeTypeV_reg ? residualV_reg : residual424k_reg;

	// ************************************************************
	// Edge controller
	// ************************************************************
	tewsh_pkg::tewsh_state_t state_reg;
	logic [7:0] amplitude_reg;
	logic edgeActive_reg;
	logic modLevel_reg;
	logic falling_reg;
	logic [7:0] startAmp_reg;
	logic [7:0] targetAmp_reg;
	logic [3:0] edgeType_reg;
	logic [2:0] edgeStyle_reg;
	logic [4:0] edgeLen_reg;
	logic stretch_reg;
	logic [4:0] stepIdx_reg;
	logic dwell_reg;

	logic edgeReq;
	logic [3:0] startType;
	logic [2:0] startStyle;
	logic [7:0] startTarget;
	logic startShaped;
	logic stepTick;
	logic lastStep;
	logic [7:0] progress;
	logic [7:0] kneeLevel;
	logic [7:0] fwShaped;
	logic [7:0] shapedProg;

	assign edgeReq = (state_reg == tewsh_pkg::ST_IDLE) && (txModulate != modLevel_reg);
	assign startType = txModulate ? cfgType[tewsh_pkg::FALL_TYPE_LSB +: 4]
		: cfgType[tewsh_pkg::RISE_TYPE_LSB +: 4];
	assign startStyle = txModulate ? cfgStyle[tewsh_pkg::FALL_STYLE_LSB +: 3]
		: cfgStyle[tewsh_pkg::RISE_STYLE_LSB +: 3];
	assign startTarget = txModulate ? cfgResidual : tewsh_pkg::FULL_CARRIER;
	// Reserved codes and a zero length both give an unshaped step
	assign startShaped = (isFwType(startType) || isLutType(startType))
		&& (cfgLength[4:0] != 5'h00);

	// A state lasts one or two carrier cycles
	assign stepTick = (state_reg == tewsh_pkg::ST_EDGE) && carrierTick
		&& (dwell_reg == stretch_reg);
	assign lastStep = stepTick && ((stepIdx_reg + 5'h01) == edgeLen_reg);

	assign progress = stepProgress(stepIdx_reg, edgeLen_reg);
	// Style acts as time constant: a larger value bends the curve harder
	assign kneeLevel = tewsh_pkg::KNEE_BASE + {1'b0, edgeStyle_reg, 4'h0};

	always_comb
	begin
		case (edgeType_reg)
			tewsh_pkg::TYPE_FW_TWO: fwShaped = kneeMap(progress, kneeLevel);
			tewsh_pkg::TYPE_FW_THREE: fwShaped = kneeMap(kneeMap(progress, kneeLevel), kneeLevel);
			default: fwShaped = progress;
		endcase
	end

	tewsh_shape_if shapeBus();

	assign shapeBus.progress = progress;
	assign shapeBus.tableSel = edgeStyle_reg[1:0];
	assign shapeBus.supplyLevel = amplifierSupply;

	always_comb
	begin
		case (edgeType_reg)
			tewsh_pkg::TYPE_LUT_CORR: shapeBus.adaptMode = tewsh_pkg::ADAPT_CORR;
			tewsh_pkg::TYPE_LUT_NOCORR: shapeBus.adaptMode = tewsh_pkg::ADAPT_NOCORR;
			default: shapeBus.adaptMode = tewsh_pkg::ADAPT_NONE;
		endcase
	end

	tewsh_lut_shaper lutShaper (
		.shapeBus(shapeBus.lookup)
	);

	assign shapedProg = isLutType(edgeType_reg) ? shapeBus.shaped : fwShaped;

	// Settings are captured at edge start so a write mid-edge cannot tear the pattern
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= tewsh_pkg::ST_IDLE;
			amplitude_reg <= tewsh_pkg::FULL_CARRIER;
			edgeActive_reg <= 1'b0;
			modLevel_reg <= 1'b0;
			falling_reg <= 1'b0;
			startAmp_reg <= tewsh_pkg::FULL_CARRIER;
			targetAmp_reg <= tewsh_pkg::FULL_CARRIER;
			edgeType_reg <= 4'h0;
			edgeStyle_reg <= 3'h0;
			edgeLen_reg <= 5'h00;
			stretch_reg <= 1'b0;
			stepIdx_reg <= 5'h00;
			dwell_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				tewsh_pkg::ST_IDLE:
				begin
					if (edgeReq)
					begin
						modLevel_reg <= txModulate;
						falling_reg <= txModulate;
						startAmp_reg <= amplitude_reg;
						targetAmp_reg <= startTarget;
						edgeType_reg <= startType;
						edgeStyle_reg <= startStyle;
						edgeLen_reg <= cfgLength[4:0];
						stretch_reg <= cfgLength[tewsh_pkg::STRETCH_BIT];
						stepIdx_reg <= 5'h00;
						dwell_reg <= 1'b0;
						if (startShaped)
						begin
							state_reg <= tewsh_pkg::ST_EDGE;
							edgeActive_reg <= 1'b1;
						end
						else
							amplitude_reg <= startTarget;
					end
				end
				tewsh_pkg::ST_EDGE:
				begin
					if (stepTick)
					begin
						dwell_reg <= 1'b0;
						stepIdx_reg <= stepIdx_reg + 5'h01;
						if (lastStep)
						begin
							amplitude_reg <= targetAmp_reg;
							state_reg <= tewsh_pkg::ST_IDLE;
							edgeActive_reg <= 1'b0;
						end
						else
							amplitude_reg <= lerpAmp(startAmp_reg, targetAmp_reg, shapedProg);
					end
					else if (carrierTick)
						dwell_reg <= 1'b1;
				end
				default:
					state_reg <= tewsh_pkg::ST_IDLE;
			endcase
		end
	end

	assign amplitude = amplitude_reg;
	assign edgeActive = edgeActive_reg;

	// ************************************************************
	// Register read
	// ************************************************************
	logic [7:0] regRdData_reg;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			regRdData_reg <= 8'h00;
		else if (!regRdEn)
			regRdData_reg <= 8'h00;
		else
		begin
			case (regAddr)
				tewsh_pkg::OFS_RESIDUAL_424K: regRdData_reg <= residual424k_reg;
				tewsh_pkg::OFS_TYPE_424K: regRdData_reg <= type424k_reg;
				tewsh_pkg::OFS_STYLE_424K: regRdData_reg <= style424k_reg;
				tewsh_pkg::OFS_LENGTH_424K: regRdData_reg <= length424k_reg;
				tewsh_pkg::OFS_RESIDUAL_TYPEV: regRdData_reg <= residualV_reg;
				tewsh_pkg::OFS_TYPE_TYPEV: regRdData_reg <= typeV_reg;
				tewsh_pkg::OFS_STYLE_TYPEV: regRdData_reg <= styleV_reg;
				tewsh_pkg::OFS_LENGTH_TYPEV: regRdData_reg <= lengthV_reg;
				tewsh_pkg::OFS_STATUS:
					regRdData_reg <= {edgeActive_reg, activeTypeV_reg, falling_reg, stepIdx_reg};
				tewsh_pkg::OFS_AMPLITUDE: regRdData_reg <= amplitude_reg;
				default: regRdData_reg <= 8'h00;
			endcase
		end
	end

	assign regRdData = regRdData_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	a_typev_residual: assert property (@(posedge clock) disable iff (!arst_n)
		edgeReq && txModulate && activeTypeV_reg |=> targetAmp_reg == $past(residualV_reg))
		else $error("Type V falling target is not the residual level");

	a_edge_lands: assert property (@(posedge clock) disable iff (!arst_n)
		lastStep |=> amplitude_reg == targetAmp_reg && !edgeActive_reg)
		else $error("Edge did not end on its target amplitude");

	a_fw_linear: assert property (@(posedge clock) disable iff (!arst_n)
		state_reg == tewsh_pkg::ST_EDGE && edgeType_reg == tewsh_pkg::TYPE_FW_ONE
		|-> shapedProg == progress)
		else $error("Single linear step is not linear");

	a_lut_adapt: assert property (@(posedge clock) disable iff (!arst_n)
		state_reg == tewsh_pkg::ST_EDGE && edgeType_reg == tewsh_pkg::TYPE_LUT_NOCORR
		|-> shapeBus.adaptMode == tewsh_pkg::ADAPT_NOCORR && shapedProg == shapeBus.shaped)
		else $error("Table shaping without correction misrouted");

	a_rise_nibble: assert property (@(posedge clock) disable iff (!arst_n)
		edgeReq && !txModulate |=> edgeType_reg == $past(cfgType[3:0]) && !falling_reg)
		else $error("Rising edge did not take the low type nibble");

	a_fall_style: assert property (@(posedge clock) disable iff (!arst_n)
		edgeReq && txModulate |=> edgeStyle_reg == $past(cfgStyle[6:4])
		&& edgeType_reg == $past(cfgType[7:4]))
		else $error("Falling edge style or type not taken");

	a_rise_style: assert property (@(posedge clock) disable iff (!arst_n)
		edgeReq && !txModulate |=> edgeStyle_reg == $past(cfgStyle[2:0]))
		else $error("Rising edge style not taken");

	a_stretch_dwell: assert property (@(posedge clock) disable iff (!arst_n)
		state_reg == tewsh_pkg::ST_EDGE && stretch_reg && carrierTick && !dwell_reg
		|=> stepIdx_reg == $past(stepIdx_reg) && dwell_reg)
		else $error("Stretched state advanced after one carrier cycle");

	a_step_count: assert property (@(posedge clock) disable iff (!arst_n)
		lastStep |-> stepIdx_reg == edgeLen_reg - 5'h01)
		else $error("Edge ended after the wrong number of states");

	a_reserved_flat: assert property (@(posedge clock) disable iff (!arst_n)
		edgeReq && !startShaped
		|=> state_reg == tewsh_pkg::ST_IDLE && amplitude_reg == $past(startTarget))
		else $error("Unshaped edge did not step at once");

	a_mode_latch: assert property (@(posedge clock) disable iff (!arst_n)
		frameActive && !frameActiveDly_reg |=> activeTypeV_reg == $past(modeTypeV))
		else $error("Frame start did not capture the mode");
endmodule // tewsh_edge_shaper

`default_nettype wire

// ==== rtl/tewsh_pkg.sv ====
package tewsh_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] OFS_RESIDUAL_424K = 8'h38;
	localparam logic [7:0] OFS_TYPE_424K = 8'h39;
	localparam logic [7:0] OFS_STYLE_424K = 8'h3a;
	localparam logic [7:0] OFS_LENGTH_424K = 8'h3b;
	localparam logic [7:0] OFS_RESIDUAL_TYPEV = 8'h4c;
	localparam logic [7:0] OFS_TYPE_TYPEV = 8'h4d;
	localparam logic [7:0] OFS_STYLE_TYPEV = 8'h4e;
	localparam logic [7:0] OFS_LENGTH_TYPEV = 8'h4f;
	localparam logic [7:0] OFS_STATUS = 8'h60;
	localparam logic [7:0] OFS_AMPLITUDE = 8'h61;

	// ************************************************************
	// Reset values and masks
	// ************************************************************
	localparam logic [7:0] RST_RESIDUAL = 8'h00;
	localparam logic [7:0] RST_TYPE = 8'h00;
	localparam logic [7:0] RST_STYLE = 8'h00;
	localparam logic [7:0] RST_LENGTH = 8'h00;
	localparam logic [7:0] MASK_STYLE = 8'h77;
	localparam logic [7:0] MASK_LENGTH = 8'h9f;
	localparam logic [7:0] FULL_CARRIER = 8'hff;
	localparam logic [7:0] ZERO_CARRIER = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int FALL_TYPE_LSB = 4;
	localparam int RISE_TYPE_LSB = 0;
	localparam int FALL_STYLE_LSB = 4;
	localparam int RISE_STYLE_LSB = 0;
	localparam int STRETCH_BIT = 7;
	localparam int STATUS_BUSY_BIT = 7;

	// ************************************************************
	// Edge type codes and shaping constants
	// ************************************************************
	localparam logic [3:0] TYPE_FW_ONE = 4'h1;
	localparam logic [3:0] TYPE_FW_TWO = 4'h2;
	localparam logic [3:0] TYPE_FW_THREE = 4'h3;
	localparam logic [3:0] TYPE_LUT_PLAIN = 4'h4;
	localparam logic [3:0] TYPE_LUT_CORR = 4'h5;
	localparam logic [3:0] TYPE_LUT_NOCORR = 4'h6;
	localparam logic [7:0] KNEE_INPUT = 8'h80;
	localparam logic [7:0] KNEE_BASE = 8'h80;

	typedef enum logic [1:0]
	{
		ADAPT_NONE = 2'b00,
		ADAPT_CORR = 2'b01,
		ADAPT_NOCORR = 2'b10
	} tewsh_adapt_t;

	typedef enum logic [0:0]
	{
		ST_IDLE = 1'b0,
		ST_EDGE = 1'b1
	} tewsh_state_t;

endpackage

// ==== rtl/tewsh_shape_if.sv ====
`timescale 1ns/1ns
`default_nettype none

interface tewsh_shape_if;
	logic [7:0] progress;
	logic [1:0] tableSel;
	tewsh_pkg::tewsh_adapt_t adaptMode;
	logic [7:0] supplyLevel;
	logic [7:0] shaped;

	modport requester
	(
		output progress,
		output tableSel,
		output adaptMode,
		output supplyLevel,
		input shaped
	);

	modport lookup
	(
		input progress,
		input tableSel,
		input adaptMode,
		input supplyLevel,
		output shaped
	);
endinterface

`default_nettype wire

// ==== rtl/tewsh_lut_shaper.sv ====
`timescale 1ns/1ns
`default_nettype none

module tewsh_lut_shaper (
	// Shaping request
	tewsh_shape_if.lookup shapeBus
);
	// ************************************************************
	// Tables, sixteen points each, entry i at bits [8*i+7:8*i]
	// ************************************************************
	localparam logic [127:0] TABLE_LINEAR = 128'hffeeddccbbaa99887766554433221100;
	localparam logic [127:0] TABLE_SLOW = 128'hfff6ece0d2c8a28062483220120802_00;
	localparam logic [127:0] TABLE_FAST = 128'hfffefcf8f2eae0d2c2ae967a5a361c00;
	localparam logic [127:0] TABLE_SCURVE = 128'hfffdf8efe0ccb2946b4d331f10070200;

	logic [127:0] tableRow;
	logic [7:0] rawLevel;
	logic [15:0] boost;

	always_comb
	begin
		case (shapeBus.tableSel)
			2'h0: tableRow = TABLE_LINEAR;
			2'h1: tableRow = TABLE_SLOW;
			2'h2: tableRow = TABLE_FAST;
			default: tableRow = TABLE_SCURVE;
		endcase
	end

	// Last point is used before the final state only in edges of 17 or more states; the edge controller lands on the target itself
	assign rawLevel = tableRow[{shapeBus.progress[7:4], 3'h0} +: 8];

	// Low supply steepens the edge so the envelope still settles inside the pattern
	assign boost = (16'h00ff - 16'(rawLevel)) * (16'h00ff - 16'(shapeBus.supplyLevel));

	always_comb
	begin
		case (shapeBus.adaptMode)
			tewsh_pkg::ADAPT_NOCORR: shapeBus.shaped = rawLevel + boost[15:8];
			tewsh_pkg::ADAPT_CORR: shapeBus.shaped = rawLevel + 8'(boost[15:9]);
			default: shapeBus.shaped = rawLevel;
		endcase
	end
endmodule // tewsh_lut_shaper

`default_nettype wire

// ==== dv/tewsh_carrier_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Carrier tick source standing in for the transmitter
// ************************************************************
module tewsh_carrier_model (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Control from the bench
	input wire logic run,
	input wire logic [1:0] period,
	// Carrier
	output logic carrierTick
);
	logic [1:0] count_reg;

	// Still outside edges, so that every tick seen belongs to one edge
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_reg <= 2'h0;
			carrierTick <= 1'b0;
		end
		else if (!run)
		begin
			count_reg <= 2'h0;
			carrierTick <= 1'b0;
		end
		else
		begin
			carrierTick <= (count_reg >= period);
			count_reg <= (count_reg >= period) ? 2'h0 : count_reg + 2'h1;
		end
	end
endmodule // tewsh_carrier_model

`default_nettype wire

// ==== dv/test_tx_edge_wave_shaper.sv ====
`timescale 1ns/1ns
`default_nettype none

module test_tx_edge_wave_shaper;
	logic clock;
	logic arst_n;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic regWrEn;
	logic regRdEn;
	logic [7:0] regRdData;
	logic modeTypeV;
	logic frameActive;
	logic txModulate;
	logic carrierTick;
	logic [7:0] amplifierSupply;
	logic [7:0] amplitude;
	logic edgeActive;
	logic run;
	logic [1:0] period;
	int seed = 68890;
	int num_errors = 0;
	int check_count = 0;
	logic [15:0] ampQ[$];
	logic [7:0] rdQ[$];

	tewsh_edge_shaper dut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.modeTypeV(modeTypeV), .frameActive(frameActive), .txModulate(txModulate),
		.carrierTick(carrierTick), .amplifierSupply(amplifierSupply),
		.amplitude(amplitude), .edgeActive(edgeActive));

	tewsh_carrier_model carrier (.clock(clock), .arst_n(arst_n), .run(run),
		.period(period), .carrierTick(carrierTick));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clock);
		regWrEn <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rdQ.push_back(exp);
		@(posedge clock);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clock);
		regRdEn <= 1'b0;
	endtask

	// Ticks run only once the edge is seen, so their count is exact
	task automatic shapeEdge(input logic m, input logic [7:0] amp, input logic [7:0] ticks);
		int n;
		n = 0;
		ampQ.push_back({amp, ticks});
		@(posedge clock);
		txModulate <= m;
		while (ampQ.size() > 0)
		begin
			@(posedge clock);
			run <= edgeActive;
			n++;
			if (n > 400)
			begin
				num_errors++;
				results();
			end
		end
		@(posedge clock);
		run <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	// ************************************************************
	// Output watcher
	// ************************************************************
	initial
	begin : watch
		logic rdFlag;
		logic [7:0] prevAmp;
		logic [7:0] ticks;
		logic [15:0] exp;
		rdFlag = 1'b0;
		prevAmp = 8'hff;
		ticks = 8'h00;
		forever
		begin
			@(posedge clock);
			if (rdFlag)
				check({8'h00, regRdData}, {8'h00, rdQ.pop_front()});
			rdFlag = regRdEn;
			if (edgeActive === 1'b1 && carrierTick === 1'b1)
				ticks++;
			if (arst_n && amplitude !== prevAmp && edgeActive === 1'b0)
			begin
				exp = (ampQ.size() > 0) ? ampQ.pop_front() : 16'h0000;
				check({amplitude, ticks}, exp);
				ticks = 8'h00;
			end
			prevAmp = amplitude;
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		logic [7:0] r;
		logic [2:0] len;
		logic [7:0] n;
		arst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		modeTypeV = 1'b0;
		frameActive = 1'b0;
		txModulate = 1'b0;
		amplifierSupply = 8'h80;
		run = 1'b0;
		period = 2'h0;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		// Reset values, then one unmapped place
		for (int i = 0; i < 8; i++)
			rd(8'h38 + 8'(i % 4) + ((i >= 4) ? 8'h14 : 8'h00), 8'h00);
		rd(8'h70, 8'h00);
		// Reserved style and length bits are kept at zero by software
		wr(8'h3a, 8'h77);
		rd(8'h3a, 8'h77);
		wr(8'h3b, 8'h9f);
		rd(8'h3b, 8'h9f);
		wr(8'h61, 8'h00);
		rd(8'h61, 8'hff);
		r = rnd() & 8'h7f;
		wr(8'h38, r);
		rd(8'h38, r);
		// Type zero and a reserved type both step straight to the target
		shapeEdge(1'b1, r, 8'h00);
		shapeEdge(1'b0, 8'hff, 8'h00);
		wr(8'h39, 8'h77);
		shapeEdge(1'b1, r, 8'h00);
		shapeEdge(1'b0, 8'hff, 8'h00);
		// Every shaping code, both stretch settings
		for (int t = 1; t < 7; t++)
			for (int s = 0; s < 2; s++)
			begin
				len = 3'(rnd());
				n = 8'({1'b0, len} + 4'h1) << s;
				wr(8'h39, {4'(t), 4'(t)});
				wr(8'h3a, rnd() & 8'h77);
				wr(8'h3b, {1'(s), 4'h0, len} + 8'h01);
				amplifierSupply <= rnd();
				period <= 2'(rnd());
				shapeEdge(1'b1, r, n);
				shapeEdge(1'b0, 8'hff, n);
			end
		// Falling shaped, rising left unshaped
		wr(8'h39, 8'h10);
		wr(8'h3b, 8'h02);
		shapeEdge(1'b1, r, 8'h02);
		shapeEdge(1'b0, 8'hff, 8'h00);
		// Type V set taken at frame start
		r = rnd() & 8'h7f;
		wr(8'h4c, r);
		wr(8'h4d, 8'h30);
		wr(8'h4f, 8'h83);
		modeTypeV <= 1'b1;
		@(posedge clock);
		frameActive <= 1'b1;
		shapeEdge(1'b1, r, 8'h06);
		rd(8'h61, r);
		shapeEdge(1'b0, 8'hff, 8'h00);
		// Status: idle, Type V set latched, last edge rising, index cleared
		rd(8'h60, 8'h40);
		rd(8'h61, 8'hff);
		frameActive <= 1'b0;
		repeat (4) @(posedge clock);
		results();
	end
endmodule // test_tx_edge_wave_shaper

`default_nettype wire
